// ### hdl/tcr_pkg.sv
// Constants and types shared by the timer register block.
package tcr_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int TCR_NUM_TIMERS = 4;
  localparam int TCR_CNT_W = 16;
  localparam int TCR_ADDR_W = 8;
  localparam int TCR_DATA_W = 32;
  localparam int TCR_IDX_W = 6;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [TCR_IDX_W-1:0] TCR_IDX_TIMER0_CAPTURE_RELOAD = 6'h00;
  localparam logic [TCR_IDX_W-1:0] TCR_IDX_TIMER0_COMPARE = 6'h01;
  localparam logic [TCR_IDX_W-1:0] TCR_IDX_TIMER1_CAPTURE_RELOAD = 6'h02;
  localparam logic [TCR_IDX_W-1:0] TCR_IDX_TIMER1_COMPARE = 6'h03;
  localparam logic [TCR_IDX_W-1:0] TCR_IDX_TIMER2_CAPTURE_RELOAD = 6'h04;
  localparam logic [TCR_IDX_W-1:0] TCR_IDX_TIMER2_COMPARE = 6'h05;
  localparam logic [TCR_IDX_W-1:0] TCR_IDX_TIMER3_CAPTURE_RELOAD = 6'h06;
  localparam logic [TCR_IDX_W-1:0] TCR_IDX_TIMER3_COMPARE = 6'h07;
  localparam logic [TCR_IDX_W-1:0] TCR_IDX_CONTROL_BASE = 6'h08;
  localparam logic [TCR_IDX_W-1:0] TCR_IDX_STATUS = 6'h0c;
  localparam logic [TCR_IDX_W-1:0] TCR_IDX_MASK = 6'h0d;
  localparam logic [TCR_IDX_W-1:0] TCR_IDX_COUNT_BASE = 6'h0e;
  localparam logic [TCR_IDX_W-1:0] TCR_IDX_LAST = 6'h11;
  localparam logic [1:0] TCR_WORD_ALIGN = 2'h0;

  // ----------------------------------------------------------------
  // Control register fields (one control register per timer)
  // ----------------------------------------------------------------
  localparam int TCR_CTL_W = 4;
  localparam int TCR_CTL_CAPSEL = 0;
  localparam int TCR_CTL_RUN = 1;
  localparam int TCR_CTL_EXTEN = 2;
  localparam int TCR_CTL_DOWN = 3;

  // ----------------------------------------------------------------
  // Status and mask fields: one bit per timer in each group
  // ----------------------------------------------------------------
  localparam int TCR_ST_W = 12;
  localparam int TCR_ST_OVF_BASE = 0;
  localparam int TCR_ST_TRIG_BASE = 4;
  localparam int TCR_ST_MATCH_BASE = 8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [TCR_CNT_W-1:0] TCR_CR_RST = 16'h0000;
  localparam logic [TCR_CNT_W-1:0] TCR_CMP_RST = 16'h0000;
  localparam logic [TCR_CNT_W-1:0] TCR_COUNT_RST = 16'h0000;
  localparam logic [TCR_CTL_W-1:0] TCR_CTL_RST = 4'h0;
  localparam logic [TCR_ST_W-1:0] TCR_ST_RST = 12'h000;
  localparam logic [TCR_DATA_W-1:0] TCR_RDATA_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Bus slave states
  // ----------------------------------------------------------------
  typedef enum logic {
    TCR_APB_IDLE = 1'b0,
    TCR_APB_RESP = 1'b1
  } tcr_apb_state_t;

endpackage : tcr_pkg

// ### hdl/tcr_timer.sv
// One 16-bit timer with its capture/reload and compare registers.
`timescale 1ns/1ps

module tcr_timer
  import tcr_pkg::*;
#(
  parameter int CNT_W = TCR_CNT_W
) (
  // Clock and reset
  input logic clk,
  input logic sys_rst,
  // Mode control
  input logic capture_select,
  input logic run_control,
  input logic external_trigger_enable,
  input logic down_count_enable,
  // Synchronised trigger pin
  input logic trig_fall,
  input logic trig_level,
  // Software writes
  input logic wr_cr,
  input logic wr_cmp,
  input logic [CNT_W-1:0] wdata,
  // State and events
  output logic [CNT_W-1:0] cr_value,
  output logic [CNT_W-1:0] cmp_value,
  output logic [CNT_W-1:0] running_count,
  output logic overflow_pulse,
  output logic trigger_pulse,
  output logic match_pulse
);

  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [CNT_W-1:0] cr_reg, cr_next;
  logic [CNT_W-1:0] cmp_reg, cmp_next;
  logic ovf_reg, ovf_next;
  logic trg_reg, trg_next;
  logic match_reg, match_next;
  logic down;

  // ----------------------------------------------------------------
  // Counting, reload, capture and compare
  // ----------------------------------------------------------------
  always_comb begin
    cnt_next = cnt_reg;
    cr_next = cr_reg;
    cmp_next = cmp_reg;
    ovf_next = 1'b0;
    trg_next = 1'b0;
    // Down counting only in reload mode, steered by the trigger pin level
    down = down_count_enable & ~capture_select & ~trig_level;
    if (wr_cr) begin
      cr_next = wdata;
    end
    if (wr_cmp) begin
      cmp_next = wdata;
    end
    if (run_control) begin
      if (down) begin
        if (cnt_reg == '0) begin
          ovf_next = 1'b1;
          cnt_next = cr_reg;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end else if (cnt_reg == '1) begin
        ovf_next = 1'b1;
        // Capture mode has no reload value, the register holds a capture
        cnt_next = capture_select ? TCR_COUNT_RST : cr_reg;
      end else begin
        cnt_next = cnt_reg + 1'b1;
      end
    end
    if (external_trigger_enable && trig_fall) begin
      trg_next = 1'b1;
      if (capture_select) begin
        // Hardware capture wins over a software write in the same cycle
        cr_next = cnt_reg;
      end else if (!down_count_enable) begin
        cnt_next = cr_reg;
      end
    end
    // Pulse once as the count arrives at the compare value
    match_next = (cnt_next != cnt_reg) && (cnt_next == cmp_reg);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg <= TCR_COUNT_RST;
      cr_reg <= TCR_CR_RST;
      cmp_reg <= TCR_CMP_RST;
      ovf_reg <= 1'b0;
      trg_reg <= 1'b0;
      match_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      cr_reg <= cr_next;
      cmp_reg <= cmp_next;
      ovf_reg <= ovf_next;
      trg_reg <= trg_next;
      match_reg <= match_next;
    end
  end

  assign cr_value = cr_reg;
  assign cmp_value = cmp_reg;
  assign running_count = cnt_reg;
  assign overflow_pulse = ovf_reg;
  assign trigger_pulse = trg_reg;
  assign match_pulse = match_reg;

endmodule : tcr_timer

// ### hdl/tcr_top.sv
// APB register block for four 16-bit capture/reload/compare timers.
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps

// Notes on behaviour
// - Four timers each own a capture/reload word and a compare word at indices 00h to 07h.
// - Any reset clears every capture/reload register to zero.
// - In capture mode a capture event copies the whole running count into capture/reload.
// - In reload mode the capture/reload value is what the count is loaded with on reload.
// - Any reset clears every compare register to zero.
// - The running count is compared with the compare register all the time.
// - Timers 1 to 3 have the same registers and behaviour as timer 0.
// - With external enable on, a trigger falling edge captures in capture mode, else reloads unless down count enable is set.
// - The timer counts while run control is set; when it is cleared the count holds except for a trigger reload.
// - Overflow, or reaching zero counting down, sets a flag that software must clear.
module tcr_top
  import tcr_pkg::*;
#(
  parameter int NUM_TIMERS = TCR_NUM_TIMERS,
  parameter int CNT_W = TCR_CNT_W
) (
  // Clock and reset
  input logic clk,
  input logic sys_rst,
  // APB slave
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [TCR_ADDR_W-1:0] paddr,
  input logic [TCR_DATA_W-1:0] pwdata,
  output logic [TCR_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Trigger pins, one per timer
  input logic [NUM_TIMERS-1:0] external_trigger_input,
  // Interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic [TCR_IDX_W:0] decode_index(input logic [TCR_ADDR_W-1:0] addr);
    logic [TCR_IDX_W-1:0] idx;
    logic ok;
    idx = addr[TCR_IDX_W+1:2];
    ok = (addr[1:0] == TCR_WORD_ALIGN) && (idx <= TCR_IDX_LAST);
    return {ok, idx};
  endfunction : decode_index

  // ----------------------------------------------------------------
  // Register groups
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TCR_GRP_CR = 3'h0,
    TCR_GRP_CMP = 3'h1,
    TCR_GRP_CTL = 3'h2,
    TCR_GRP_STATUS = 3'h3,
    TCR_GRP_MASK = 3'h4,
    TCR_GRP_COUNT = 3'h5
  } tcr_grp_t;

  // Group of an index; only meaningful when the index is valid
  function automatic tcr_grp_t index_group(input logic [TCR_IDX_W-1:0] i);
    tcr_grp_t g;
    if (i < TCR_IDX_CONTROL_BASE) begin
      g = i[0] ? TCR_GRP_CMP : TCR_GRP_CR;
    end else if (i < TCR_IDX_STATUS) begin
      g = TCR_GRP_CTL;
    end else if (i == TCR_IDX_STATUS) begin
      g = TCR_GRP_STATUS;
    end else if (i == TCR_IDX_MASK) begin
      g = TCR_GRP_MASK;
    end else begin
      g = TCR_GRP_COUNT;
    end
    return g;
  endfunction : index_group

  // Two select bits cover four timers; more timers need a wider select
  function automatic logic [1:0] index_timer(input logic [TCR_IDX_W-1:0] i);
    logic [TCR_IDX_W-1:0] rel;
    rel = i >> 1;
    if (i >= TCR_IDX_COUNT_BASE) begin
      rel = i - TCR_IDX_COUNT_BASE;
    end else if (i >= TCR_IDX_CONTROL_BASE) begin
      rel = i - TCR_IDX_CONTROL_BASE;
    end
    return rel[1:0];
  endfunction : index_timer

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  tcr_apb_state_t state_reg, state_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [TCR_DATA_W-1:0] prdata_reg, prdata_next;
  logic irq_reg, irq_next;
  logic [TCR_CTL_W-1:0] ctl_reg [NUM_TIMERS];
  logic [TCR_CTL_W-1:0] ctl_next [NUM_TIMERS];
  logic [TCR_ST_W-1:0] status_reg, status_next;
  logic [TCR_ST_W-1:0] mask_reg, mask_next;
  logic [NUM_TIMERS-1:0] trig_meta_reg, trig_sync_reg, trig_prev_reg;
  logic [NUM_TIMERS-1:0] trig_fall;

  logic [TCR_IDX_W:0] dec;
  logic [TCR_IDX_W-1:0] idx;
  logic idx_ok;
  tcr_grp_t grp;
  logic [1:0] tsel;
  logic wr_status;
  logic wr_mask;
  logic commit;
  logic [NUM_TIMERS-1:0] wr_cr, wr_cmp;
  logic [TCR_ST_W-1:0] st_set, st_clr;
  logic [CNT_W-1:0] cr_value [NUM_TIMERS];
  logic [CNT_W-1:0] cmp_value [NUM_TIMERS];
  logic [CNT_W-1:0] count_value [NUM_TIMERS];
  logic [NUM_TIMERS-1:0] ovf_pulse, trg_pulse, match_pulse;

  assign dec = decode_index(paddr);
  assign idx = dec[TCR_IDX_W-1:0];
  assign idx_ok = dec[TCR_IDX_W];
  // A write lands on the edge where the master sees pready high
  assign commit = psel && penable && pwrite && pready_reg && idx_ok;

  // ----------------------------------------------------------------
  // Register select
  // ----------------------------------------------------------------
  // One decode feeds the write strobes and the read mux, so they cannot disagree
  assign grp = index_group(idx);
  assign tsel = index_timer(idx);
  assign wr_status = commit && (grp == TCR_GRP_STATUS);
  assign wr_mask = commit && (grp == TCR_GRP_MASK);

  // ----------------------------------------------------------------
  // Trigger pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      // Pins idle high so release from reset makes no false edge
      trig_meta_reg <= '1;
      trig_sync_reg <= '1;
      trig_prev_reg <= '1;
    end else begin
      trig_meta_reg <= external_trigger_input;
      trig_sync_reg <= trig_meta_reg;
      trig_prev_reg <= trig_sync_reg;
    end
  end

  assign trig_fall = trig_prev_reg & ~trig_sync_reg;

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_TIMERS; gi++) begin : g_timer
      assign wr_cr[gi] = commit && (grp == TCR_GRP_CR) && (tsel == 2'(gi));
      assign wr_cmp[gi] = commit && (grp == TCR_GRP_CMP) && (tsel == 2'(gi));

      tcr_timer #(
        .CNT_W(CNT_W)
      ) u_timer (
        .clk(clk),
        .sys_rst(sys_rst),
        .capture_select(ctl_reg[gi][TCR_CTL_CAPSEL]),
        .run_control(ctl_reg[gi][TCR_CTL_RUN]),
        .external_trigger_enable(ctl_reg[gi][TCR_CTL_EXTEN]),
        .down_count_enable(ctl_reg[gi][TCR_CTL_DOWN]),
        .trig_fall(trig_fall[gi]),
        .trig_level(trig_sync_reg[gi]),
        .wr_cr(wr_cr[gi]),
        .wr_cmp(wr_cmp[gi]),
        .wdata(pwdata[CNT_W-1:0]),
        .cr_value(cr_value[gi]),
        .cmp_value(cmp_value[gi]),
        .running_count(count_value[gi]),
        .overflow_pulse(ovf_pulse[gi]),
        .trigger_pulse(trg_pulse[gi]),
        .match_pulse(match_pulse[gi])
      );

      assign st_set[TCR_ST_OVF_BASE+gi] = ovf_pulse[gi];
      assign st_set[TCR_ST_TRIG_BASE+gi] = trg_pulse[gi];
      assign st_set[TCR_ST_MATCH_BASE+gi] = match_pulse[gi];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Control, status and mask registers
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NUM_TIMERS; i++) begin
      ctl_next[i] = ctl_reg[i];
      if (commit && (grp == TCR_GRP_CTL) && (tsel == 2'(i))) begin
        ctl_next[i] = pwdata[TCR_CTL_W-1:0];
      end
    end
    // Mask shares the status layout: each event is enabled at its own bit
    mask_next = mask_reg;
    if (wr_mask) begin
      mask_next = pwdata[TCR_ST_W-1:0];
    end
    st_clr = '0;
    if (wr_status) begin
      st_clr = pwdata[TCR_ST_W-1:0];
    end
    // A new event in the clearing cycle is kept
    status_next = (status_reg & ~st_clr) | st_set;
    irq_next = |(status_next & mask_next);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        ctl_reg[i] <= TCR_CTL_RST;
      end
      status_reg <= TCR_ST_RST;
      mask_reg <= TCR_ST_RST;
      irq_reg <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        ctl_reg[i] <= ctl_next[i];
      end
      status_reg <= status_next;
      mask_reg <= mask_next;
      irq_reg <= irq_next;
    end
  end

  // ----------------------------------------------------------------
  // APB slave: one wait state, answer registered
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    prdata_next = prdata_reg;
    case (state_reg)
      TCR_APB_IDLE: begin
        if (psel && penable) begin
          state_next = TCR_APB_RESP;
          pready_next = 1'b1;
          pslverr_next = !idx_ok;
          prdata_next = TCR_RDATA_RST;
          if (!pwrite && idx_ok) begin
            // Bits above each field stay zero from the clear above
            case (grp)
              TCR_GRP_CR: begin
                prdata_next[CNT_W-1:0] = cr_value[tsel];
              end
              TCR_GRP_CMP: begin
                prdata_next[CNT_W-1:0] = cmp_value[tsel];
              end
              TCR_GRP_CTL: begin
                prdata_next[TCR_CTL_W-1:0] = ctl_reg[tsel];
              end
              TCR_GRP_STATUS: begin
                prdata_next[TCR_ST_W-1:0] = status_reg;
              end
              TCR_GRP_MASK: begin
                prdata_next[TCR_ST_W-1:0] = mask_reg;
              end
              default: begin
                // Live count, read only
                prdata_next[CNT_W-1:0] = count_value[tsel];
              end
            endcase
          end
        end
      end
      TCR_APB_RESP: begin
        // The master drops penable at this edge, so IDLE cannot retake the transfer
        state_next = TCR_APB_IDLE;
      end
      default: begin
        state_next = TCR_APB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= TCR_APB_IDLE;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= TCR_RDATA_RST;
    end else begin
      state_reg <= state_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq = irq_reg;

endmodule : tcr_top

// ### sim/tcr_monitor.sv
// Bus protocol, decode and reset checks on the timer register block.
`timescale 1ns/1ps

module tcr_monitor
  import tcr_pkg::*;
(
  // Clock and reset
  input logic clk,
  input logic sys_rst,
  // APB slave side
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [TCR_ADDR_W-1:0] paddr,
  input logic [TCR_DATA_W-1:0] prdata,
  input logic pready,
  input logic pslverr,
  // Interrupt
  input logic irq
);
  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  // Until software writes, every register must still read its reset value
  logic wr_seen_reg;
  logic wr_seen_next;
  logic acc;
  logic bad;
  assign acc = psel && penable && !pready;
  assign bad = (paddr[7:2] > TCR_IDX_LAST) || (paddr[1:0] != TCR_WORD_ALIGN);
  always_comb begin
    wr_seen_next = wr_seen_reg | (pready & pwrite);
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_seen_reg <= 1'b0;
    end else begin
      wr_seen_reg <= wr_seen_next;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_acc_rdy; acc |=> pready; endproperty
  a_acc_rdy: assert property (p_acc_rdy) else $error("no answer");
  property p_rdy_one; pready |=> !pready; endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("long ready");
  property p_idle; !(psel && penable) |=> !pready; endproperty
  a_idle: assert property (p_idle) else $error("stray ready");
  property p_err; acc && bad |=> pready && pslverr; endproperty
  a_err: assert property (p_err) else $error("no error");
  property p_ok; acc && !bad |=> !pslverr; endproperty
  a_ok: assert property (p_ok) else $error("false error");
  property p_err_rd; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
  a_err_rd: assert property (p_err_rd) else $error("error data");
  property p_upper; pready |-> prdata[31:16] == 16'h0000; endproperty
  a_upper: assert property (p_upper) else $error("upper bits");
  property p_rst_rd;
    pready && !pwrite && !wr_seen_reg && !pslverr |-> prdata == 32'h0;
  endproperty
  a_rst_rd: assert property (p_rst_rd) else $error("reset value");
  property p_irq0; !wr_seen_reg |-> !irq; endproperty
  a_irq0: assert property (p_irq0) else $error("early irq");

  c_wr: cover property (pready && pwrite);
  c_err: cover property (pready && pslverr);
  c_irq: cover property ($rose(irq));
endmodule : tcr_monitor

bind tcr_top tcr_monitor u_mon (
  .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq)
);

// ### sim/testbench.sv
// Self-checking random bench for the timer register block.
`timescale 1ns/1ps

module testbench
  import tcr_pkg::*;
;
  logic clk;
  logic sys_rst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] external_trigger_input;
  logic irq;
  logic [31:0] rdat;
  logic rerr;
  logic [31:0] d;
  logic [31:0] c;
  logic [31:0] v;
  logic [31:0] r [4];
  int k;
  int num_errors;
  int n_compared;

  tcr_top dut (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_trigger_input(external_trigger_input), .irq(irq)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] ba(input int idx);
    return 8'(idx * 4);
  endfunction : ba
  function automatic logic [31:0] lo16(input logic [31:0] x);
    return {16'h0000, x[15:0]};
  endfunction : lo16
  function automatic logic [31:0] flag(input logic x);
    return {31'h0, x};
  endfunction : flag

  // No wait bound here: the watchdog cuts a missing pready short
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic end_sim;
    if (num_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Overflow of a 16-bit count from zero dominates the run time
  initial begin
    repeat (95000) @(posedge clk);
    num_errors++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    external_trigger_input = 4'hf;
    num_errors = 0;
    n_compared = 0;
    d = $urandom(32'hd393);
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i <= 17; i++) begin
      apb(1'b0, ba(i), 32'h0);
      chk("reset value", 32'h0, rdat);
    end
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 8; i++) begin
        d = p ? $urandom : 32'hffff_ffff;
        apb(1'b1, ba(i), d);
        apb(1'b0, ba(i), 32'h0);
        chk("readback", lo16(d), rdat);
      end
    end
    apb(1'b1, ba(14), 32'h5555);
    apb(1'b0, ba(14), 32'h0);
    chk("count write", 32'h0, rdat);
    apb(1'b0, ba(18), 32'h0);
    chk("unmapped", 32'h1, flag(rerr));
    apb(1'b1, 8'h02, 32'h1);
    chk("misaligned", 32'h1, flag(rerr));
    for (int i = 0; i < 4; i++) begin
      r[i] = $urandom & 32'h7fff;
      apb(1'b1, ba(2 * i), r[i]);
    end
    apb(1'b1, ba(13), 32'hf);
    for (int i = 0; i < 4; i++) apb(1'b1, ba(8 + i), 32'h2);
    for (k = 0; k < 70000 && irq !== 1'b1; k++) @(posedge clk);
    repeat (30) @(posedge clk);
    apb(1'b0, ba(12), 32'h0);
    chk("overflow", 32'hf, rdat & 32'hf);
    for (int i = 0; i < 4; i++) apb(1'b1, ba(8 + i), 32'h0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, ba(14 + i), 32'h0);
      c = rdat;
      apb(1'b0, ba(14 + i), 32'h0);
      chk("hold", c, rdat);
      chk("reload", 32'h1, flag(c - r[i] < 100));
    end
    chk("irq", 32'h1, flag(irq));
    apb(1'b1, ba(13), 32'h0);
    repeat (3) @(posedge clk);
    chk("irq masked", 32'h0, flag(irq));
    apb(1'b1, ba(13), 32'hf);
    repeat (3) @(posedge clk);
    chk("irq unmasked", 32'h1, flag(irq));
    apb(1'b1, ba(12), 32'hfff);
    repeat (3) @(posedge clk);
    chk("irq cleared", 32'h0, flag(irq));
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ba(8 + i), 32'h7);
      apb(1'b0, ba(14 + i), 32'h0);
      c = rdat;
      external_trigger_input[i] <= 1'b0;
      repeat (8) @(posedge clk);
      apb(1'b0, ba(2 * i), 32'h0);
      v = rdat;
      apb(1'b0, ba(14 + i), 32'h0);
      chk("capture", 32'h1, flag(v > c && v < rdat));
      external_trigger_input[i] <= 1'b1;
      apb(1'b1, ba(2 * i + 1), rdat + 60);
      repeat (80) @(posedge clk);
      apb(1'b0, ba(12), 32'h0);
      chk("events", 32'h11, (rdat >> (4 + i)) & 32'h11);
      // Small reload value keeps the down-count pass short
      r[i] = $urandom & 32'h3f;
      apb(1'b1, ba(2 * i), r[i]);
      apb(1'b1, ba(8 + i), 32'h6);
      external_trigger_input[i] <= 1'b0;
      repeat (8) @(posedge clk);
      apb(1'b0, ba(14 + i), 32'h0);
      chk("trigger reload", 32'h1, flag(rdat - r[i] < 20));
      // Pin still low: down counting reaches zero, flags and reloads
      apb(1'b1, ba(8 + i), 32'he);
      repeat (120) @(posedge clk);
      apb(1'b0, ba(12), 32'h0);
      chk("down overflow", 32'h1, (rdat >> i) & 32'h1);
      apb(1'b0, ba(14 + i), 32'h0);
      chk("down reload", 32'h1, flag(rdat <= r[i]));
      external_trigger_input[i] <= 1'b1;
      apb(1'b1, ba(8 + i), 32'h0);
    end
    end_sim();
  end
endmodule : testbench
